// ===== design/sdo_cmd_pkg.sv
package sdo_cmd_pkg;
    localparam int unsigned CLK_HZ           = 250_000_000;
    localparam int unsigned TICK_NS          = 120_000;
    // 120 us tick in 4 ns cycles, rounded down as a longest time
    localparam int unsigned TICK_CYCLES      = TICK_NS / (1_000_000_000 / CLK_HZ);
    localparam int unsigned MODE_ACC_BIT     = 2;
    localparam logic [1:0]  MODE_READ_REG    = 2'h0;
    localparam logic [1:0]  MODE_WRITE_REG   = 2'h1;
    localparam logic [1:0]  MODE_WRITE_CONST = 2'h2;
    localparam logic [7:0]  NET_PREOP        = 8'h7F;
    localparam logic [7:0]  NET_OPER         = 8'h05;
    localparam logic [7:0]  NET_STOP         = 8'h04;
    localparam logic [6:0]  NODE_ID_RESET    = 7'h00;
    localparam logic [2:0]  FLAGS_RESET      = 3'h0;
    localparam logic [3:0]  ADDR_STATUS      = 4'h0;
    localparam logic [3:0]  ADDR_EVENTS      = 4'h1;
    localparam logic [3:0]  ADDR_MASK        = 4'h2;
    localparam logic [3:0]  ADDR_IDENT       = 4'h3;
    localparam int unsigned EV_DONE          = 0;
    localparam int unsigned EV_TIMEOUT       = 1;
    localparam int unsigned EV_ACCESS_ERR    = 2;
    localparam int unsigned EV_CMD_ERR       = 3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01
    } sdo_state_type;

    // condition flags of the internal status word
    typedef struct packed {
        logic positive;
        logic zero;
        logic negative;
    } cond_flags_type;

    typedef struct packed {
        logic [2:0]  mode;
        logic [31:0] data;
        logic [15:0] index;
        logic [7:0]  sub_index;
        logic [15:0] byte_count;
        logic [15:0] timeout;
        logic [1:0]  client;
    } remote_cmd_type;

    // request toward the local sdo client
    typedef struct packed {
        logic        start;
        logic        client_sel;
        logic        upload;
        logic        data_is_reg;
        logic [31:0] data;
        logic [15:0] index;
        logic [7:0]  sub_index;
        logic [15:0] byte_count;
    } sdo_req_type;
endpackage : sdo_cmd_pkg

// ===== design/tick_timer.sv
`timescale 1ns/1ns
`default_nettype none
module tick_timer
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic        run_i,
    input  wire logic [15:0] limit_i,
    output var  logic        expired_o
);
    typedef struct packed {
        logic [15:0] pre;
        logic [15:0] ticks;
        logic        expired;
    } tmr_state_type;

    tmr_state_type st;
    tmr_state_type next_st;

    // counts 120 us ticks while run_i is high, then flags expiry
    always_comb
    begin
        next_st = st;
        if (!run_i)
        begin
            next_st = '0;
        end
        else if (!st.expired)
        begin
            if (st.ticks >= limit_i)
            begin
                next_st.expired = 1'b1;
            end
            else if (st.pre == 16'(sdo_cmd_pkg::TICK_CYCLES - 1))
            begin
                next_st.pre   = 16'h0000;
                next_st.ticks = st.ticks + 16'h0001;
            end
            else
            begin
                next_st.pre = st.pre + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign expired_o = st.expired;
endmodule : tick_timer
`default_nettype wire

// ===== design/node_identity.sv
`timescale 1ns/1ns
`default_nettype none
module node_identity
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic        cmd_i,
    input  wire logic [15:0] id_i,
    input  wire logic [7:0]  net_state_i,
    input  wire logic [7:0]  serial_id_i,
    output var  logic [6:0]  node_id_o,
    output var  logic        can_enable_o,
    output var  logic        cob_reinit_o,
    output var  logic        cmd_error_o,
    output var  logic        cmd_done_o
);
    typedef struct packed {
        logic [6:0] node_id;
        logic       id_set;
        logic       reinit;
        logic       err;
        logic       done;
    } id_state_type;

    id_state_type st;
    id_state_type next_st;
    logic [15:0]  neg_id;
    logic [6:0]   chosen;
    logic         id_ok;
    logic         state_ok;

    always_comb
    begin
        next_st        = st;
        next_st.reinit = 1'b0;
        next_st.err    = 1'b0;
        next_st.done   = 1'b0;
        neg_id         = 16'h0000 - id_i;
        chosen         = 7'h00;
        id_ok          = 1'b0;
        state_ok       = (net_state_i != sdo_cmd_pkg::NET_OPER)
                      && (net_state_i != sdo_cmd_pkg::NET_STOP);
        if (id_i == 16'h0000)
        begin
            chosen = serial_id_i[6:0];
            id_ok  = (chosen != 7'h00);
        end
        else if (!id_i[15] && id_i <= 16'h007F)
        begin
            chosen = id_i[6:0];
            id_ok  = 1'b1;
        end
        else if (id_i[15] && neg_id <= 16'h007F)
        begin
            chosen = neg_id[6:0];
            id_ok  = 1'b1;
        end
        if (cmd_i)
        begin
            next_st.done = 1'b1;
            if (!state_ok || !id_ok)
            begin
                next_st.err = 1'b1;
            end
            else
            begin
                next_st.node_id = chosen;
                next_st.id_set  = 1'b1;
                next_st.reinit  = !st.id_set || id_i[15];
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign node_id_o    = st.node_id;
    assign can_enable_o = st.id_set;
    assign cob_reinit_o = st.reinit;
    assign cmd_error_o  = st.err;
    assign cmd_done_o   = st.done;

    a_id_reject_state : assert property (@(posedge clk_sys_i) disable iff (rst_i)
        cmd_i && (net_state_i == sdo_cmd_pkg::NET_OPER) |=> cmd_error_o && $stable(node_id_o))
        else $error("identity accepted in operational state");
    a_id_serial_zero : assert property (@(posedge clk_sys_i) disable iff (rst_i)
        cmd_i && id_i == 16'h0000 && serial_id_i[6:0] == 7'h00 |=> cmd_error_o)
        else $error("zero serial id not refused");
endmodule : node_identity
`default_nettype wire

// ===== design/sdo_remote_access.sv
`timescale 1ns/1ns
`default_nettype none
module sdo_remote_access
(
    input  wire logic                        clk_sys_i,
    input  wire logic                        rst_i,
    input  wire logic                        remote_dictionary_access_cmd_i,
    input  wire sdo_cmd_pkg::remote_cmd_type remote_cmd_i,
    input  wire logic                        node_identity_cmd_i,
    input  wire logic [15:0]                 node_identity_value_i,
    input  wire logic [7:0]                  net_state_i,
    input  wire logic [7:0]                  serial_id_i,
    input  wire logic                        sdo_done_i,
    input  wire logic                        sdo_abort_i,
    input  wire logic [3:0]                  reg_addr_i,
    input  wire logic [31:0]                 reg_wdata_i,
    input  wire logic                        reg_write_i,
    input  wire logic                        reg_read_i,
    output var  sdo_cmd_pkg::sdo_req_type    sdo_req_o,
    output var  logic                        sdo_cancel_o,
    output var  logic                        cmd_busy_o,
    output var  logic                        cmd_done_o,
    output var  logic                        cmd_error_o,
    output var  sdo_cmd_pkg::cond_flags_type internal_status_word_o,
    output var  logic [6:0]                  node_id_o,
    output var  logic                        can_enable_o,
    output var  logic                        cob_reinit_o,
    output var  logic [31:0]                 reg_rdata_o,
    output var  logic                        irq_o
);
    typedef struct packed {
        sdo_cmd_pkg::sdo_state_type   fsm;
        logic                         acc;
        logic                         client_sel;
        logic [15:0]                  timeout;
        sdo_cmd_pkg::sdo_req_type     req;
        logic                         cancel;
        logic                         done;
        logic                         cmd_err;
        sdo_cmd_pkg::cond_flags_type  flags;
        logic [3:0]                   events;
        logic [3:0]                   mask;
        logic [31:0]                  rdata;
    } main_state_type;

    main_state_type              st;
    main_state_type              next_st;
    sdo_cmd_pkg::cond_flags_type result;
    logic                        finish;
    logic                        mode_ok;
    logic [3:0]                  ev_set;
    logic                        timed_out;
    logic                        id_err;
    logic                        id_done;
    logic [6:0]                  id_value;
    logic                        id_enable;
    logic                        id_reinit;

    tick_timer u_timer
    (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .run_i     (st.fsm == sdo_cmd_pkg::ST_WAIT),
        .limit_i   (st.timeout),
        .expired_o (timed_out)
    );

    node_identity u_ident
    (
        .clk_sys_i    (clk_sys_i),
        .rst_i        (rst_i),
        .cmd_i        (node_identity_cmd_i),
        .id_i         (node_identity_value_i),
        .net_state_i  (net_state_i),
        .serial_id_i  (serial_id_i),
        .node_id_o    (id_value),
        .can_enable_o (id_enable),
        .cob_reinit_o (id_reinit),
        .cmd_error_o  (id_err),
        .cmd_done_o   (id_done)
    );

    always_comb
    begin
        next_st           = st;
        next_st.req.start = 1'b0;
        next_st.cancel    = 1'b0;
        next_st.done      = 1'b0;
        next_st.cmd_err   = 1'b0;
        result            = '0;
        finish            = 1'b0;
        ev_set            = 4'h0;
        mode_ok           = (remote_cmd_i.mode[1:0] != 2'h3)
                         && (remote_cmd_i.client == 2'h1 || remote_cmd_i.client == 2'h2);
        unique case (st.fsm)
            sdo_cmd_pkg::ST_IDLE:
            begin
                if (remote_dictionary_access_cmd_i)
                begin
                    if (!mode_ok)
                    begin
                        next_st.cmd_err = 1'b1;
                        next_st.done    = 1'b1;
                        ev_set[sdo_cmd_pkg::EV_CMD_ERR] = 1'b1;
                    end
                    else
                    begin
                        next_st.fsm                = sdo_cmd_pkg::ST_WAIT;
                        next_st.acc                = remote_cmd_i.mode[sdo_cmd_pkg::MODE_ACC_BIT];
                        next_st.timeout            = remote_cmd_i.timeout;
                        next_st.client_sel         = (remote_cmd_i.client == 2'h2);
                        next_st.req.start          = 1'b1;
                        next_st.req.client_sel     = (remote_cmd_i.client == 2'h2);
                        next_st.req.upload         = (remote_cmd_i.mode[1:0]
                                                     == sdo_cmd_pkg::MODE_READ_REG);
                        next_st.req.data_is_reg    = (remote_cmd_i.mode[1:0]
                                                     != sdo_cmd_pkg::MODE_WRITE_CONST);
                        next_st.req.data           = remote_cmd_i.data;
                        next_st.req.index          = remote_cmd_i.index;
                        next_st.req.sub_index      = remote_cmd_i.sub_index;
                        next_st.req.byte_count     = remote_cmd_i.byte_count;
                    end
                end
            end
            sdo_cmd_pkg::ST_WAIT:
            begin
                if (sdo_abort_i)
                begin
                    result.negative = 1'b1;
                    finish          = 1'b1;
                    ev_set[sdo_cmd_pkg::EV_ACCESS_ERR] = 1'b1;
                end
                else if (sdo_done_i)
                begin
                    result.zero = 1'b1;
                    finish      = 1'b1;
                    ev_set[sdo_cmd_pkg::EV_DONE] = 1'b1;
                end
                else if (timed_out)
                begin
                    result.positive = 1'b1;
                    finish          = 1'b1;
                    next_st.cancel  = 1'b1;
                    ev_set[sdo_cmd_pkg::EV_TIMEOUT] = 1'b1;
                end
                if (finish)
                begin
                    next_st.fsm  = sdo_cmd_pkg::ST_IDLE;
                    next_st.done = 1'b1;
                    if (st.acc)
                    begin
                        // series result: any error sticks, zero only if all succeeded
                        next_st.flags.positive = st.flags.positive | result.positive;
                        next_st.flags.negative = st.flags.negative | result.negative;
                        next_st.flags.zero     = st.flags.zero & result.zero;
                    end
                    else
                    begin
                        next_st.flags = result;
                    end
                end
            end
            default:
            begin
                next_st.fsm = sdo_cmd_pkg::ST_IDLE;
            end
        endcase
        if (id_err)
        begin
            next_st.cmd_err = 1'b1;
            ev_set[sdo_cmd_pkg::EV_CMD_ERR] = 1'b1;
        end
        if (id_done)
        begin
            next_st.done = 1'b1;
        end
        // register port: events write one to clear, mask is written directly, a new event wins over the clear
        if (reg_write_i && reg_addr_i == sdo_cmd_pkg::ADDR_EVENTS)
        begin
            next_st.events = st.events & ~reg_wdata_i[3:0];
        end
        if (reg_write_i && reg_addr_i == sdo_cmd_pkg::ADDR_MASK)
        begin
            next_st.mask = reg_wdata_i[3:0];
        end
        next_st.events = next_st.events | ev_set;
        next_st.rdata  = 32'h0000_0000;
        if (reg_read_i)
        begin
            unique case (reg_addr_i)
                sdo_cmd_pkg::ADDR_STATUS: next_st.rdata = {26'h0, st.client_sel, st.fsm == sdo_cmd_pkg::ST_WAIT,
                                                           1'b0, st.flags};
                sdo_cmd_pkg::ADDR_EVENTS: next_st.rdata = {28'h0, st.events};
                sdo_cmd_pkg::ADDR_MASK:   next_st.rdata = {28'h0, st.mask};
                sdo_cmd_pkg::ADDR_IDENT:  next_st.rdata = {23'h0, id_reinit, id_enable, id_value};
                default:                  next_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            st       <= '0;
            st.fsm   <= sdo_cmd_pkg::ST_IDLE;
            st.flags <= sdo_cmd_pkg::FLAGS_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign sdo_req_o              = st.req;
    assign sdo_cancel_o           = st.cancel;
    assign cmd_busy_o             = (st.fsm == sdo_cmd_pkg::ST_WAIT);
    assign cmd_done_o             = st.done;
    assign cmd_error_o            = st.cmd_err;
    assign internal_status_word_o = st.flags;
    assign node_id_o              = id_value;
    assign can_enable_o           = id_enable;
    assign cob_reinit_o           = id_reinit;
    assign reg_rdata_o            = st.rdata;
    assign irq_o                  = |(st.events & st.mask);

    a_flag_timeout : assert property (@(posedge clk_sys_i) disable iff (rst_i)
        cmd_busy_o && timed_out && !sdo_done_i && !sdo_abort_i && !st.acc
        |=> internal_status_word_o == 3'h4 && !cmd_busy_o)
        else $error("timeout flags wrong");
    a_cancel_timeout : assert property (@(posedge clk_sys_i) disable iff (rst_i)
        cmd_busy_o && timed_out && !sdo_done_i && !sdo_abort_i
        |=> sdo_cancel_o && cmd_done_o)
        else $error("timeout did not cancel");
    a_flag_abort : assert property (@(posedge clk_sys_i) disable iff (rst_i)
        cmd_busy_o && sdo_abort_i && !st.acc |=> internal_status_word_o == 3'h1)
        else $error("access error flags wrong");
    a_flag_done : assert property (@(posedge clk_sys_i) disable iff (rst_i)
        cmd_busy_o && sdo_done_i && !sdo_abort_i && !st.acc |=> internal_status_word_o == 3'h2)
        else $error("completion flags wrong");
    a_acc_keeps : assert property (@(posedge clk_sys_i) disable iff (rst_i)
        cmd_busy_o && st.acc && st.flags.negative |=> internal_status_word_o.negative)
        else $error("accumulated negative lost");
    a_req_decode : assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !cmd_busy_o && remote_dictionary_access_cmd_i && remote_cmd_i.mode == 3'h2
        && remote_cmd_i.client == 2'h1
        |=> sdo_req_o.start && !sdo_req_o.upload && !sdo_req_o.data_is_reg && !sdo_req_o.client_sel)
        else $error("mode 2 request decoded wrong");
    a_refuse_client : assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !cmd_busy_o && remote_dictionary_access_cmd_i && remote_cmd_i.client == 2'h0
        |=> cmd_error_o && cmd_done_o && !cmd_busy_o && $stable(internal_status_word_o))
        else $error("bad client not refused");
endmodule : sdo_remote_access
`default_nettype wire

// ===== verification/sdo_server_model.sv
`timescale 1ns/1ns
`default_nettype none
// remote sdo server: answers each request delay_i + 1 cycles after it samples req_i.start
// resp_i 0 completes, 1 refuses the object, 2 never answers
module sdo_server_model
(
    input  wire logic                     clk_sys_i,
    input  wire logic                     rst_i,
    input  wire sdo_cmd_pkg::sdo_req_type req_i,
    input  wire logic                     cancel_i,
    input  wire logic [1:0]               resp_i,
    input  wire logic [7:0]               delay_i,
    output var  logic                     done_o,
    output var  logic                     abort_o
);
    logic       pending;
    logic [7:0] count;

    always_ff @(posedge clk_sys_i)
    begin
        done_o  <= 1'b0;
        abort_o <= 1'b0;
        if (rst_i || cancel_i)
            pending <= 1'b0;
        else if (req_i.start)
        begin
            pending <= 1'b1;
            count   <= delay_i;
        end
        else if (pending && count != 8'h00)
            count <= count - 8'h01;
        else if (pending)
        begin
            pending <= 1'b0;
            done_o  <= (resp_i == 2'h0);
            abort_o <= (resp_i == 2'h1);
        end
    end
endmodule : sdo_server_model
`default_nettype wire

// ===== verification/sdo_remote_access_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module sdo_remote_access_tb_top;
    logic                        clk_sys_i = 1'b0;
    logic                        rst_i     = 1'b1;
    logic                        rcmd_go   = 1'b0;
    sdo_cmd_pkg::remote_cmd_type rcmd      = '0;
    logic                        id_go     = 1'b0;
    logic [15:0]                 id_val    = 16'h0000;
    logic [7:0]                  net_state = 8'h00;
    logic [7:0]                  serial_id = 8'h00;
    logic [3:0]                  reg_addr  = 4'h0;
    logic [31:0]                 reg_wdata = 32'h0000_0000;
    logic                        reg_wr    = 1'b0;
    logic                        reg_rd    = 1'b0;
    logic [1:0]                  resp_mode = 2'h0;
    logic                        sdo_done, sdo_abort, sdo_cancel, busy, done, err;
    logic                        can_en, reinit, irq;
    sdo_cmd_pkg::sdo_req_type    req;
    sdo_cmd_pkg::cond_flags_type flags;
    logic [6:0]                  node_id;
    logic [31:0]                 rdata;
    int                          failures = 0;
    int                          samples_checked = 0;
    logic                        st, e, canc;
    int                          cyc;

    initial
    begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    sdo_remote_access u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .remote_dictionary_access_cmd_i(rcmd_go), .remote_cmd_i(rcmd),
        .node_identity_cmd_i(id_go), .node_identity_value_i(id_val),
        .net_state_i(net_state), .serial_id_i(serial_id), .sdo_done_i(sdo_done),
        .sdo_abort_i(sdo_abort), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_write_i(reg_wr), .reg_read_i(reg_rd), .sdo_req_o(req),
        .sdo_cancel_o(sdo_cancel), .cmd_busy_o(busy), .cmd_done_o(done),
        .cmd_error_o(err), .internal_status_word_o(flags), .node_id_o(node_id),
        .can_enable_o(can_en), .cob_reinit_o(reinit), .reg_rdata_o(rdata), .irq_o(irq));

    sdo_server_model u_server (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req),
        .cancel_i(sdo_cancel), .resp_i(resp_mode), .delay_i(8'h05),
        .done_o(sdo_done), .abort_o(sdo_abort));

    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string nm);
        @(posedge clk_sys_i);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd <= 1'b0;
        #1;
        chk(nm, exp, rdata);
    endtask : rd

    task automatic remote(input logic [2:0] mode, input logic [31:0] data,
        input logic [1:0] cl, input logic [15:0] tmo, input logic [1:0] resp);
        @(posedge clk_sys_i);
        resp_mode <= resp;
        rcmd_go   <= 1'b1;
        rcmd      <= '{mode, data, 16'h2101, 8'h01, 16'h0004, tmo, cl};
        @(posedge clk_sys_i);
        rcmd_go <= 1'b0;
        #1;
        st   = req.start;
        canc = 1'b0;
        for (cyc = 0; cyc < 40000; cyc++)
        begin
            canc = canc | sdo_cancel;
            if (done === 1'b1)
                break;
            @(posedge clk_sys_i);
            #1;
        end
        e = err;
        if (cyc == 40000)
        begin
            failures++;
            test_done();
        end
    endtask : remote

    task automatic ident(input logic [15:0] v, input logic [7:0] ns, input logic [7:0] ser);
        @(posedge clk_sys_i);
        net_state <= ns;
        serial_id <= ser;
        id_go     <= 1'b1;
        id_val    <= v;
        @(posedge clk_sys_i);
        id_go <= 1'b0;
        canc = 1'b0;
        for (cyc = 0; cyc < 10; cyc++)
        begin
            #1;
            canc = canc | reinit;
            if (done === 1'b1)
                break;
            @(posedge clk_sys_i);
        end
        e = err;
        chk("ident_done", 1'b1, done);
        if (cyc == 10)
            test_done();
    endtask : ident

    task automatic t_transfer;
        remote(3'h0, 32'h0000_001E, 2'h2, 16'h0001, 2'h0);
        chk("up_start", 1'b1, st);
        chk("up_flags", 3'b010, flags);
        chk("up_dir", 2'b11, {req.upload, req.data_is_reg});
        chk("up_client", 1'b1, req.client_sel);
        chk("up_bytes", 16'h0004, req.byte_count);
        chk("up_reg", 32'h0000_001E, req.data);
        chk("up_index", 24'h2101_01, {req.index, req.sub_index});
        remote(3'h1, 32'h0000_0020, 2'h1, 16'h0001, 2'h1);
        chk("dn_flags", 3'b001, flags);
        chk("dn_dir", 2'b01, {req.upload, req.data_is_reg});
        chk("dn_client", 1'b0, req.client_sel);
        $display("t_transfer finished");
    endtask : t_transfer

    task automatic t_timeout;
        remote(3'h0, 32'h0000_0001, 2'h1, 16'h0001, 2'h2);
        chk("tmo_flags", 3'b100, flags);
        chk("tmo_cancel", 1'b1, canc);
        chk("tmo_length", 1'b1, cyc > 29000 && cyc < 31000);
        $display("t_timeout finished");
    endtask : t_timeout

    task automatic t_accum;
        remote(3'h2, 32'hA5C3_0F12, 2'h1, 16'h0001, 2'h0);
        chk("cst_flags", 3'b010, flags);
        chk("cst_dir", 2'b00, {req.upload, req.data_is_reg});
        chk("cst_data", 32'hA5C3_0F12, req.data);
        remote(3'h6, 32'h0000_0005, 2'h1, 16'h0001, 2'h1);
        chk("acc_neg", 3'b001, flags);
        remote(3'h4, 32'h0000_0005, 2'h2, 16'h0001, 2'h0);
        chk("acc_keep", 3'b001, flags);
        chk("acc_dir", 2'b11, {req.upload, req.data_is_reg});
        remote(3'h5, 32'h0000_0005, 2'h1, 16'h0000, 2'h2);
        chk("acc_both", 3'b101, flags);
        remote(3'h0, 32'h0000_0005, 2'h1, 16'h0001, 2'h0);
        chk("acc_clear", 3'b010, flags);
        $display("t_accum finished");
    endtask : t_accum

    task automatic t_refuse;
        remote(3'h3, 32'h0000_0001, 2'h1, 16'h0000, 2'h0);
        chk("bad_mode", 3'b100, {e, st, busy});
        remote(3'h0, 32'h0000_0001, 2'h0, 16'h0000, 2'h0);
        chk("bad_client", 2'b10, {e, st});
        chk("bad_flags", 3'b010, flags);
        $display("t_refuse finished");
    endtask : t_refuse

    task automatic t_ident;
        ident(16'h0005, sdo_cmd_pkg::NET_OPER, 8'h00);
        chk("id_oper", 3'b100, {e, can_en, canc});
        ident(16'h0005, sdo_cmd_pkg::NET_STOP, 8'h00);
        chk("id_stop", 3'b100, {e, can_en, canc});
        ident(16'h0005, sdo_cmd_pkg::NET_PREOP, 8'h00);
        chk("id_first", 10'b0_1_1_0000101, {e, can_en, canc, node_id});
        ident(16'h0009, sdo_cmd_pkg::NET_PREOP, 8'h00);
        chk("id_change", 9'b0_0_0001001, {e, canc, node_id});
        ident(16'hFFF7, sdo_cmd_pkg::NET_PREOP, 8'h00);
        chk("id_negated", 9'b0_1_0001001, {e, canc, node_id});
        ident(16'h0000, 8'h00, 8'h80);
        chk("id_serial0", 8'b1_0001001, {e, node_id});
        ident(16'h0000, 8'h00, 8'h85);
        chk("id_serial", 8'b0_0000101, {e, node_id});
        $display("t_ident finished");
    endtask : t_ident

    task automatic t_regs;
        wr(sdo_cmd_pkg::ADDR_EVENTS, 32'h0000_000F);
        wr(sdo_cmd_pkg::ADDR_MASK, 32'h0000_0000);
        rd(sdo_cmd_pkg::ADDR_EVENTS, 32'h0000_0000, "ev_clear");
        remote(3'h0, 32'h0000_0001, 2'h1, 16'h0001, 2'h0);
        rd(sdo_cmd_pkg::ADDR_EVENTS, 32'h0000_0001, "ev_done");
        chk("irq_masked", 1'b0, irq);
        wr(sdo_cmd_pkg::ADDR_MASK, 32'h0000_0001);
        chk("irq_on", 1'b1, irq);
        wr(sdo_cmd_pkg::ADDR_MASK, 32'h0000_0002);
        chk("irq_other", 1'b0, irq);
        wr(sdo_cmd_pkg::ADDR_MASK, 32'h0000_0001);
        wr(sdo_cmd_pkg::ADDR_EVENTS, 32'h0000_0001);
        chk("irq_cleared", 1'b0, irq);
        rd(sdo_cmd_pkg::ADDR_STATUS, 32'h0000_0002, "status");
        rd(sdo_cmd_pkg::ADDR_IDENT, 32'h0000_0085, "ident");
        rd(4'hF, 32'h0000_0000, "unmapped");
        $display("t_regs finished");
    endtask : t_regs

    initial
    begin
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        chk("rst_flags", 3'b000, flags);
        t_transfer();
        t_timeout();
        t_accum();
        t_refuse();
        t_ident();
        t_regs();
        test_done();
    end
endmodule : sdo_remote_access_tb_top
`default_nettype wire
